// File: design/ufb_core.sv
// serial frame transmitter/receiver core with fractional baud divider and AHB-Lite registers
//
// Contract
// R1: frame is low start bit, data bits, optional parity, high stop bits.
// R2: 5 to 9 data bits, none/even/odd parity, 1 or 2 stops.
// R3: line idles high; next frame may follow stop bits directly.
// R4: divisor holds factor shifted left six; low six bits are fraction.
// R5: async rate is 64*clk/(S*divisor), S=16 normal, 8 double speed.
// R6: sync host rate is clk/(2*divisor[15:6]); fraction written zero.
// R7: software keeps divisor between 64 and 65535.
// R8: data registers move to buffer, then to shifter when free.
// R9: transmit complete sets when frame ends with nothing else pending.
// R10: empty flag shows data registers may be written; only then.
// R11: upper data bits beyond character size are ignored on transmit.
// R12: nine-bit writes follow the selected byte order.
// R13: transmitter disable waits for all pending data, then releases pin.
// R14: receive starts on valid start bit; second stop bit ignored.
// R15: first stop bit stores frame in buffer, sets receive complete.
// R16: two-entry receive buffer; oldest frame is presented.
// R17: high byte read advances buffer in nine-bit low-first, else low.
// R18: software reads the non-advancing byte first.
// R19: invalid frames detected; overflow reported when buffer full.
// R20: open-drain mode makes the transmit pin an output automatically.
// R21: loopback routes transmit line into the receiver.
// R22: software sets divisor, format, pin, then enables.
// R23: error flags travel with their frame, read in high byte.
// R24: receiver disable is immediate, flushing buffer and frame.
// R25: frame error when first stop bit is sampled low.
`timescale 1ns/1ps
module ufb_core (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word transfers only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic rxdPin, // receive pin
  output logic txdOut, // transmit pin output value
  output logic txdOeN, // transmit pin output enable, low drives
  output logic txDirOut, // transmit pin direction is output
  output logic xckOut // transfer clock in sync host mode
);
  import ufb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and derived settings
  ufbCtrl_type ctrl_q;
  ufbFmt_type fmt_q;
  logic [15:0] baud_q;
  logic [4:0] samples;
  logic [16:0] baudEff;
  logic [3:0] nBits;
  logic parOn;
  logic parOdd;
  logic nineLow;

  always_comb begin
    nBits = (fmt_q.charSize < 3'h4) ? {1'b0, fmt_q.charSize} + 4'h5 : 4'h9; // [R2]
    parOn = fmt_q.parity[1];
    parOdd = (fmt_q.parity == PAR_ODD);
    nineLow = (fmt_q.charSize == CS_9_LOW_FIRST);
    if (fmt_q.mode == MODE_SYNC_HOST) begin
      samples = S_SYNC;
      baudEff = {1'b0, baud_q[15:6], 6'h00}; // [R6]
    end else begin
      samples = ctrl_q.dblSpeed ? S_DOUBLE : S_NORMAL; // [R5]
      baudEff = {1'b0, baud_q}; // [R4]
    end
    // an out-of-range divisor is clamped so the accumulator cannot run away
    if (baudEff < BAUD_STEP) begin
      baudEff = BAUD_STEP;
    end
  end

  function automatic logic [8:0] maskData(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = 9'h000;
    for (int i = 0; i < 9; i++) begin
      m[i] = (i < n) ? d[i] : 1'b0;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // fractional sample tick: 64 added per clock, divisor subtracted per tick
  logic [16:0] acc_q;
  logic sampleTick;

  always_comb begin
    sampleTick = (acc_q + BAUD_STEP) >= baudEff; // [R4] [R5]
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 17'h00000;
    end else if (sampleTick) begin
      acc_q <= acc_q + BAUD_STEP - baudEff;
    end else begin
      acc_q <= acc_q + BAUD_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, read data registered at the address phase
  logic addrPhase;
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] rdMux;
  logic rdPop;
  logic wrTxLow;
  logic wrTxHigh;
  logic wrStatus;
  logic [1:0] rxCnt_q;
  ufbRxEntry_type rxE0_q;
  ufbRxEntry_type rxE1_q;
  logic txDataValid_q;
  logic txc_q;

  always_comb begin
    addrPhase = hsel && htrans[1] && hready;
    wrTxLow = wrPend_q && (wrAddr_q == OFS_TX_LOW);
    wrTxHigh = wrPend_q && (wrAddr_q == OFS_TX_HIGH);
    wrStatus = wrPend_q && (wrAddr_q == OFS_STATUS);
    rdMux = 32'h00000000;
    unique case (haddr[7:0])
      OFS_RX_LOW: rdMux[7:0] = rxE0_q.data[7:0];
      OFS_RX_HIGH: begin
        rdMux[HI_RXC_BIT] = (rxCnt_q != 2'h0);
        rdMux[HI_OVF_BIT] = rxE0_q.ovf; // [R23]
        rdMux[HI_FRAME_ERROR_FLAG_BIT] = rxE0_q.frame_error_flag; // [R23]
        rdMux[HI_PARITY_ERROR_FLAG_BIT] = rxE0_q.parity_error_flag; // [R23]
        rdMux[0] = rxE0_q.data[8];
      end
      OFS_STATUS: begin
        rdMux[ST_RXC_BIT] = (rxCnt_q != 2'h0);
        rdMux[ST_TXC_BIT] = txc_q;
        rdMux[ST_DRE_BIT] = !txDataValid_q; // [R10]
      end
      OFS_ENABLE_CTRL: begin
        rdMux[CT_RXEN_BIT] = ctrl_q.rxEn;
        rdMux[CT_TXEN_BIT] = ctrl_q.txEn;
        rdMux[CT_OD_BIT] = ctrl_q.openDrain;
        rdMux[CT_DBL_BIT] = ctrl_q.dblSpeed;
        rdMux[CT_LB_BIT] = ctrl_q.loopback;
      end
      OFS_FRAME_FMT: rdMux[7:0] = fmt_q;
      OFS_BAUD: rdMux[15:0] = baud_q;
      default: rdMux = 32'h00000000;
    endcase
    // the register that advances the buffer depends on the byte order
    rdPop = addrPhase && !hwrite && (rxCnt_q != 2'h0) &&
            (haddr[7:0] == (nineLow ? OFS_RX_HIGH : OFS_RX_LOW)); // [R17]
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_q <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= '0;
      fmt_q <= FMT_RESET;
      baud_q <= BAUD_RESET;
    end else if (wrPend_q) begin
      if (wrAddr_q == OFS_ENABLE_CTRL) begin
        ctrl_q <= '{rxEn: hwdata[CT_RXEN_BIT], txEn: hwdata[CT_TXEN_BIT], openDrain: hwdata[CT_OD_BIT],
                    dblSpeed: hwdata[CT_DBL_BIT], loopback: hwdata[CT_LB_BIT]};
      end
      if (wrAddr_q == OFS_FRAME_FMT) begin
        fmt_q <= hwdata[7:0];
      end
      if (wrAddr_q == OFS_BAUD) begin
        baud_q <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit path: data registers, buffer, shifter
  ufbTxState_type txState_q;
  logic [8:0] txData_q;
  logic [8:0] txBuf_q;
  logic txBufValid_q;
  logic [11:0] txShift_q;
  logic [3:0] txRemain_q;
  logic [4:0] txSamp_q;
  logic txLine_q;
  logic txActive_q;
  logic txBitEnd;
  logic txFrameEnd;
  logic txLoad;
  logic txBufTake;
  logic [12:0] txFrame;
  logic [3:0] txLen;
  logic [8:0] txMasked;

  always_comb begin
    txBitEnd = (txState_q == TX_SHIFT) && sampleTick && (txSamp_q == samples - 5'h01);
    txFrameEnd = txBitEnd && (txRemain_q == 4'h0);
    txLoad = txActive_q && txBufValid_q && ((txState_q == TX_IDLE) || txFrameEnd); // [R3] [R8]
    txBufTake = txDataValid_q && (!txBufValid_q || txLoad); // [R8]
    txMasked = maskData(txBuf_q, nBits); // [R11]
    txFrame = 13'h1FFF;
    txFrame[0] = 1'b0; // [R1]
    for (int i = 0; i < 9; i++) begin
      if (i < nBits) begin
        txFrame[i + 1] = txMasked[i];
      end
    end
    if (parOn) begin
      txFrame[nBits + 4'h1] = (^txMasked) ^ parOdd; // [R2]
    end
    txLen = 4'h1 + nBits + {3'h0, parOn} + {3'h0, fmt_q.twoStop} + 4'h1; // [R1] [R2]
  end

  // data registers: a write is only taken while they are empty
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txData_q <= 9'h000;
      txDataValid_q <= 1'b0;
    end else begin
      if (txBufTake) begin
        txDataValid_q <= 1'b0;
      end
      if (wrTxLow && !txDataValid_q) begin // [R10]
        txData_q[7:0] <= hwdata[7:0];
        txDataValid_q <= !nineLow; // [R12]
      end
      if (wrTxHigh && !txDataValid_q) begin // [R10]
        txData_q[8] <= hwdata[0];
        txDataValid_q <= nineLow; // [R12]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txBuf_q <= 9'h000;
      txBufValid_q <= 1'b0;
    end else if (txBufTake) begin
      txBuf_q <= txData_q;
      txBufValid_q <= 1'b1;
    end else if (txLoad) begin
      txBufValid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txState_q <= TX_IDLE;
      txShift_q <= 12'hFFF;
      txRemain_q <= 4'h0;
      txSamp_q <= 5'h00;
      txLine_q <= 1'b1;
    end else if (txLoad) begin
      txState_q <= TX_SHIFT;
      txLine_q <= txFrame[0];
      txShift_q <= txFrame[12:1];
      txRemain_q <= txLen - 4'h1;
      txSamp_q <= 5'h00;
    end else if (txFrameEnd) begin
      txState_q <= TX_IDLE;
      txLine_q <= 1'b1; // [R3]
    end else if (txBitEnd) begin
      txLine_q <= txShift_q[0];
      txShift_q <= {1'b1, txShift_q[11:1]};
      txRemain_q <= txRemain_q - 4'h1;
      txSamp_q <= 5'h00;
    end else if ((txState_q == TX_SHIFT) && sampleTick) begin
      txSamp_q <= txSamp_q + 5'h01;
    end
  end

  // set beats a software clear landing in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txc_q <= 1'b0;
    end else if (txFrameEnd && !txBufValid_q && !txDataValid_q) begin
      txc_q <= 1'b1; // [R9]
    end else if (wrStatus && hwdata[ST_TXC_BIT]) begin
      txc_q <= 1'b0;
    end
  end

  // enable drops only when nothing is left to send
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txActive_q <= 1'b0;
    end else if (ctrl_q.txEn) begin
      txActive_q <= 1'b1;
    end else if (txState_q == TX_IDLE && !txBufValid_q && !txDataValid_q) begin
      txActive_q <= 1'b0; // [R13]
    end
  end

  // pin control; in open drain the pad is driven only for a low bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      txdOut <= 1'b1;
      txdOeN <= 1'b1;
      txDirOut <= 1'b0;
      xckOut <= 1'b0;
    end else begin
      txDirOut <= txActive_q || ctrl_q.openDrain; // [R13] [R20]
      if (!txActive_q) begin
        txdOut <= 1'b1;
        txdOeN <= 1'b1; // [R13]
      end else if (ctrl_q.openDrain) begin
        txdOut <= 1'b0;
        txdOeN <= txLine_q; // [R20]
      end else begin
        txdOut <= txLine_q;
        txdOeN <= 1'b0;
      end
      if (fmt_q.mode == MODE_SYNC_HOST && txState_q == TX_SHIFT) begin
        xckOut <= sampleTick ? !xckOut : xckOut; // [R6]
      end else begin
        xckOut <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive path: pin synchroniser, sampler and two-entry buffer
  logic rxMeta_q;
  logic rxSync_q;
  logic rxPrev_q;
  logic rxIn;
  ufbRxState_type rxState_q;
  logic [4:0] rxSamp_q;
  logic [3:0] rxIdx_q;
  logic [8:0] rxShift_q;
  logic rxPar_q;
  logic rxMid;
  logic rxBitPt;
  logic rxDone;
  ufbRxEntry_type rxNew;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= rxdPin;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxIn;
    end
  end

  always_comb begin
    rxIn = ctrl_q.loopback ? txLine_q : rxSync_q; // [R21]
    rxMid = sampleTick && (rxSamp_q == {1'b0, samples[4:1]} - 5'h01);
    rxBitPt = sampleTick && (rxSamp_q == samples - 5'h01);
    rxDone = (rxState_q == RX_STOP) && rxBitPt; // [R15]
    rxNew.data = maskData(rxShift_q, nBits);
    rxNew.frame_error_flag = !rxIn; // [R19] [R25]
    rxNew.parity_error_flag = parOn && (rxPar_q != ((^rxNew.data) ^ parOdd)); // [R19]
    rxNew.ovf = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxState_q <= RX_IDLE;
      rxSamp_q <= 5'h00;
      rxIdx_q <= 4'h0;
      rxShift_q <= 9'h000;
      rxPar_q <= 1'b0;
    end else if (!ctrl_q.rxEn) begin
      rxState_q <= RX_IDLE; // [R24]
    end else begin
      if (sampleTick) begin
        rxSamp_q <= rxBitPt || (rxState_q == RX_START && rxMid) ? 5'h00 : rxSamp_q + 5'h01;
      end
      unique case (rxState_q)
        RX_IDLE: begin
          if (rxPrev_q && !rxIn) begin
            rxState_q <= RX_START;
            rxSamp_q <= 5'h00;
          end
        end
        RX_START: begin
          if (rxMid) begin
            // a start bit that is high again at mid-bit was a glitch
            rxState_q <= rxIn ? RX_IDLE : RX_DATA; // [R14]
            rxIdx_q <= 4'h0;
            rxShift_q <= 9'h000;
          end
        end
        RX_DATA: begin
          if (rxBitPt) begin
            if (rxIdx_q < nBits) begin
              rxShift_q[rxIdx_q] <= rxIn;
            end else begin
              rxPar_q <= rxIn;
            end
            rxIdx_q <= rxIdx_q + 4'h1;
            if (rxIdx_q == nBits - 4'h1 + {3'h0, parOn}) begin
              rxState_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // only the first stop bit is looked at
          if (rxBitPt) begin
            rxState_q <= RX_IDLE; // [R14]
          end
        end
      endcase
    end
  end

  // oldest frame always sits in entry 0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxCnt_q <= 2'h0;
      rxE0_q <= '0;
      rxE1_q <= '0;
    end else if (!ctrl_q.rxEn) begin
      rxCnt_q <= 2'h0; // [R24]
    end else if (rxDone && rxCnt_q == 2'h2 && !rdPop) begin
      rxE1_q.ovf <= 1'b1; // [R19]
    end else begin
      if (rdPop) begin
        rxE0_q <= rxE1_q; // [R16]
      end
      if (rxDone) begin
        if (rxCnt_q - {1'b0, rdPop} == 2'h0) begin
          rxE0_q <= rxNew; // [R15] [R16]
        end else begin
          rxE1_q <= rxNew; // [R15]
        end
      end
      rxCnt_q <= rxCnt_q - {1'b0, rdPop} + {1'b0, rxDone};
    end
  end
endmodule // ufb_core

// File: design/ufb_pkg.sv
// shared constants, field layouts and types for the serial frame core
package ufb_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_RX_LOW = 8'h00;
  localparam logic [7:0] OFS_RX_HIGH = 8'h04;
  localparam logic [7:0] OFS_TX_LOW = 8'h08;
  localparam logic [7:0] OFS_TX_HIGH = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ENABLE_CTRL = 8'h14;
  localparam logic [7:0] OFS_FRAME_FMT = 8'h18;
  localparam logic [7:0] OFS_BAUD = 8'h1C;
  // field positions
  localparam int HI_RXC_BIT = 7;
  localparam int HI_OVF_BIT = 6;
  localparam int HI_FRAME_ERROR_FLAG_BIT = 2;
  localparam int HI_PARITY_ERROR_FLAG_BIT = 1;
  localparam int ST_RXC_BIT = 7;
  localparam int ST_TXC_BIT = 6;
  localparam int ST_DRE_BIT = 5;
  localparam int CT_RXEN_BIT = 7;
  localparam int CT_TXEN_BIT = 6;
  localparam int CT_OD_BIT = 3;
  localparam int CT_DBL_BIT = 1;
  localparam int CT_LB_BIT = 0;
  // field encodings
  localparam logic [2:0] CS_9_LOW_FIRST = 3'h6;
  localparam logic [2:0] CS_9_HIGH_FIRST = 3'h7;
  localparam logic [1:0] MODE_SYNC_HOST = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // reset values
  localparam logic [7:0] FMT_RESET = 8'h03;
  localparam logic [15:0] BAUD_RESET = 16'h0000;
  // divider step: the divisor carries six fraction bits
  localparam logic [16:0] BAUD_STEP = 17'h00040;
  // samples per bit
  localparam logic [4:0] S_NORMAL = 5'h10;
  localparam logic [4:0] S_DOUBLE = 5'h08;
  localparam logic [4:0] S_SYNC = 5'h02;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] parity;
    logic twoStop;
    logic [2:0] charSize;
  } ufbFmt_type;

  typedef struct packed {
    logic rxEn;
    logic txEn;
    logic openDrain;
    logic dblSpeed;
    logic loopback;
  } ufbCtrl_type;

  typedef struct packed {
    logic ovf;
    logic frame_error_flag;
    logic parity_error_flag;
    logic [8:0] data;
  } ufbRxEntry_type;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } ufbRxState_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } ufbTxState_type;
endpackage

// File: bench/ufb_checker.sv
// port-level assertions for the serial frame core
`timescale 1ns/1ps
module ufb_checker (
  input wire logic sys_clk, // clock
  input wire logic reset_n, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic hready, // bus ready
  input wire logic hreadyout, // slave ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hresp, // response
  input wire logic txdOut, // pin value
  input wire logic txdOeN, // pin enable, low drives
  input wire logic txDirOut, // pin direction output
  input wire logic xckOut // transfer clock
);
  logic pinLvl;
  // the wire has a pull-up, so a released pin reads high
  assign pinLvl = txdOeN | txdOut;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  chk_ready_high: assert property ($past(reset_n) |-> hreadyout)
    else $error("slave ready dropped");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");
  chk_rdata_width: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data bits set");
  chk_drive_dir: assert property (!txdOeN |-> txDirOut)
    else $error("pin driven while direction is input");
  chk_release_pin: assert property (!txDirOut [*2] |-> txdOeN)
    else $error("released pin still driven");
  chk_bit_len: assert property ($changed(pinLvl) |=> $stable(pinLvl))
    else $error("line bit shorter than two clocks");
  chk_xck_frame: assert property ($changed(xckOut) |-> txDirOut || $past(txDirOut))
    else $error("transfer clock moved outside a frame");
endmodule // ufb_checker

// File: bench/ufb_serial_node.sv
// remote serial node: drives the receive pin and samples the transmit wire
`timescale 1ns/1ps
module ufb_serial_node (
  input wire logic sys_clk, // bench clock
  input wire logic lineIn, // level on the transmit wire
  output logic lineOut // level driven onto the receive pin
);
  initial lineOut = 1'b1;
  // bits[0] is the start bit; the line returns to idle for one bit afterwards
  task automatic send(input logic [11:0] bits, input int nb, input int bitClks);
    for (int i = 0; i < nb; i++) begin
      lineOut <= bits[i];
      repeat (bitClks) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
    repeat (bitClks) @(posedge sys_clk);
  endtask
  // samples mid-bit from the falling start edge; unsampled bits read high
  task automatic grab(input int nb, input int bitClks, output logic [11:0] bits);
    bits = 12'hFFF;
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge sys_clk);
    for (int i = 0; i < nb; i++) begin
      bits[i] = lineIn;
      repeat (bitClks) @(posedge sys_clk);
    end
  endtask
endmodule // ufb_serial_node

// File: bench/ufb_core_tb.sv
// self-checking bench for the serial frame core
`timescale 1ns/1ps
module ufb_core_tb;
  import ufb_pkg::*;
  logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, rxdPin, txdOut, txdOeN, txDirOut, xckOut, txLine;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int mismatches, compares;
  assign txLine = txdOeN | txdOut;
  ufb_core i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxdPin(rxdPin), .txdOut(txdOut), .txdOeN(txdOeN),
    .txDirOut(txDirOut), .xckOut(xckOut));
  ufb_serial_node i_node (.sys_clk(sys_clk), .lineIn(txLine), .lineOut(rxdPin));
  ////////////////////////////////////////
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x & m, e);
  endtask
  // polls status under a bounded count; the caller judges the outcome
  task automatic wait_flag(input logic [31:0] m);
    logic [31:0] x;
    x = 32'h0;
    for (int n = 0; n < 500 && (x & m) == 32'h0; n++) xfer(1'b0, OFS_STATUS, 32'h0, x);
  endtask
  // start, lsb-first data, parity, then high stop bits
  function automatic logic [11:0] frame(input logic [8:0] d, input int nd, input logic [1:0] par);
    logic [11:0] f;
    logic p;
    f = 12'hFFF;
    f[0] = 1'b0;
    p = (par == PAR_ODD);
    for (int i = 0; i < nd; i++) begin
      f[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (par[1]) f[nd + 1] = p;
    return f;
  endfunction
  ////////////////////////////////////////
  // disables the transmitter right behind the data write: the frame must still go out whole
  task automatic tx_one(input logic [31:0] fmt, ctrl, baud, d, input int nd, input logic [1:0] par,
      input int ns, bitClks);
    logic [11:0] got;
    wr(OFS_BAUD, baud);
    wr(OFS_FRAME_FMT, fmt);
    wr(OFS_ENABLE_CTRL, ctrl);
    fork
      i_node.grab(1 + nd + int'(par[1]) + ns, bitClks, got);
      begin
        wr(OFS_TX_LOW, d);
        // only the enable goes: speed and mode must hold until the frame is out
        wr(OFS_ENABLE_CTRL, ctrl & 32'hFFFFFFBF);
      end
    join
    chk({20'h0, got}, {20'h0, frame(d[8:0], nd, par)});
    wait_flag(32'h40);
    rdchk(OFS_STATUS, 32'h60, 32'h60);
    chk({31'h0, txDirOut}, 32'h0);
    wr(OFS_STATUS, 32'h40);
  endtask
  task automatic test_reset;
    rdchk(OFS_STATUS, 32'hFF, 32'h20);
    rdchk(OFS_FRAME_FMT, 32'hFF, 32'h03);
    rdchk(OFS_BAUD, 32'hFFFF, 32'h0);
    rdchk(8'h20, 32'hFFFFFFFF, 32'h0);
    chk({30'h0, txDirOut, txdOeN}, 32'h1);
  endtask
  task automatic test_tx;
    tx_one(32'h03, 32'h40, 32'h40, 32'hA5, 8, 2'h0, 1, 16);
    tx_one(32'h2A, 32'h42, 32'h40, 32'hFF, 7, PAR_EVEN, 2, 8);
    tx_one(32'h30, 32'h40, 32'h60, 32'h13, 5, PAR_ODD, 1, 24);
    tx_one(32'h43, 32'h40, 32'h100, 32'h5A, 8, 2'h0, 1, 8);
  endtask
  task automatic rx_in(input logic [8:0] d, input int nd, input logic [1:0] par, input logic [11:0] flip);
    i_node.send(frame(d, nd, par) ^ flip, 2 + nd + int'(par[1]), 16);
  endtask
  task automatic test_rx;
    wr(OFS_BAUD, 32'h40);
    wr(OFS_FRAME_FMT, 32'h03);
    wr(OFS_ENABLE_CTRL, 32'h80);
    rx_in(9'h03C, 8, 2'h0, 12'h000);
    wait_flag(32'h80);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'h80);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h3C);
    rdchk(OFS_STATUS, 32'h80, 32'h0);
    rx_in(9'h081, 8, 2'h0, 12'h200);
    wait_flag(32'h80);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'h84);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h81);
    rx_in(9'h011, 8, 2'h0, 12'h000);
    rx_in(9'h022, 8, 2'h0, 12'h000);
    rx_in(9'h033, 8, 2'h0, 12'h000);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'h80);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h11);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'hC0);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h22);
    rdchk(OFS_STATUS, 32'h80, 32'h0);
    // five bits, odd parity, two stops: the second stop is just idle to the receiver
    wr(OFS_FRAME_FMT, 32'h38);
    rx_in(9'h1F3, 5, PAR_ODD, 12'h000);
    wait_flag(32'h80);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'h80);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h13);
    wr(OFS_FRAME_FMT, 32'h23);
    rx_in(9'h001, 8, PAR_EVEN, 12'h200);
    wait_flag(32'h80);
    rdchk(OFS_RX_HIGH, 32'hFF, 32'h82);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h01);
    rx_in(9'h055, 8, PAR_EVEN, 12'h000);
    wait_flag(32'h80);
    wr(OFS_ENABLE_CTRL, 32'h0);
    wr(OFS_ENABLE_CTRL, 32'h80);
    rdchk(OFS_STATUS, 32'h80, 32'h0);
  endtask
  task automatic test_loop;
    wr(OFS_FRAME_FMT, 32'h06);
    wr(OFS_ENABLE_CTRL, 32'hC1);
    wr(OFS_TX_LOW, 32'h55);
    wr(OFS_TX_HIGH, 32'h01);
    wait_flag(32'h80);
    rdchk(OFS_RX_LOW, 32'hFF, 32'h55);
    rdchk(OFS_STATUS, 32'h80, 32'h80);
    rdchk(OFS_RX_HIGH, 32'h81, 32'h81);
    rdchk(OFS_STATUS, 32'h80, 32'h0);
    // nine bits, high byte first: the low write completes the word, the low read advances
    wr(OFS_FRAME_FMT, 32'h07);
    wr(OFS_TX_HIGH, 32'h01);
    wr(OFS_TX_LOW, 32'hAA);
    wait_flag(32'h80);
    rdchk(OFS_RX_HIGH, 32'h81, 32'h81);
    rdchk(OFS_STATUS, 32'h80, 32'h80);
    rdchk(OFS_RX_LOW, 32'hFF, 32'hAA);
    rdchk(OFS_STATUS, 32'h80, 32'h0);
    wr(OFS_ENABLE_CTRL, 32'h08);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, txDirOut, txdOeN}, 32'h3);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // a whole run needs well under a tenth of this span
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    $display("watchdog expired at %0t", $time);
    finish_test;
  end
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    test_reset;
    test_tx;
    test_rx;
    test_loop;
    finish_test;
  end
endmodule // ufb_core_tb
bind ufb_core ufb_checker i_chk (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .txdOut(txdOut), .txdOeN(txdOeN), .txDirOut(txDirOut), .xckOut(xckOut));
